// >>> dnh_map.vh
`ifndef DNH_MAP_VH
`define DNH_MAP_VH

// register offsets (holding register numbers)
`define DNH_REG_UNUSED 16'h0000
`define DNH_REG_FREQ_HI 16'h0001
`define DNH_REG_FREQ_LO 16'h0002
`define DNH_REG_DETAIL 16'h0003
`define DNH_REG_COARSE 16'h0004
`define DNH_REG_MOTION 16'h0005
`define DNH_REG_LOOP_FB 16'h0006
`define DNH_REG_RSVD_FIRST 16'h0007
`define DNH_REG_RSVD_LAST 16'h0010
`define DNH_REG_TRIP_CNT 16'h0011
`define DNH_REG_TRIP_BASE 16'h0012

// trip record layout
`define DNH_TRIP_RECS 5
`define DNH_TRIP_WORDS 10
`define DNH_TRIP_BITS 160
`define DNH_FLD_FACTOR 4'h0
`define DNH_FLD_STATE 4'h1
`define DNH_FLD_FREQ_HI 4'h2
`define DNH_FLD_FREQ_LO 4'h3
`define DNH_FLD_CURRENT 4'h4
`define DNH_FLD_VOLTAGE 4'h5
`define DNH_FLD_RUN_HI 4'h6
`define DNH_FLD_RUN_LO 4'h7
`define DNH_FLD_PON_HI 4'h8
`define DNH_FLD_PON_LO 4'h9

// network ranges and scaling
`define DNH_FREQ_MAX 32'h00009c40
`define DNH_LOOP_FB_MAX 16'h2710
`define DNH_TRIP_CNT_MAX 16'hfffa
`define DNH_SCALE_HUNDRED 16'h0064
`define DNH_SRC_NETWORK 8'h03

// reset values
`define DNH_FREQ_RST 32'h00000000
`define DNH_LOOP_FB_RST 16'h0000

`endif

// >>> dnh_scale.v
`timescale 1ns/1ps
`include "dnh_map.vh"
// network integer to engineering value: whole units and hundredths
module dnh_scale (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [15:0] net_value,
  output reg [15:0] whole,
  output reg [6:0] hundredths
);

  wire [15:0] quot;
  wire [15:0] rem;

  assign quot = net_value / `DNH_SCALE_HUNDRED;
  assign rem = net_value % `DNH_SCALE_HUNDRED;

  always @(posedge clk) begin
    if (!rst_n) begin
      whole <= 16'h0000;
      hundredths <= 7'h00;
    end else if (load) begin
      whole <= quot;
      hundredths <= rem[6:0];
    end
  end

endmodule // dnh_scale

// >>> dnh_trip_store.v
`timescale 1ns/1ps
`include "dnh_map.vh"
// trip history: record 0 newest, older ones shift down on each trip
module dnh_trip_store (
  input wire clk,
  input wire rst_n,
  input wire capture,
  input wire [`DNH_TRIP_BITS-1:0] new_rec,
  input wire [2:0] rd_rec,
  input wire [3:0] rd_fld,
  output wire [15:0] rd_word
);

  reg [`DNH_TRIP_BITS-1:0] rec_r [0:`DNH_TRIP_RECS-1];
  wire [`DNH_TRIP_BITS-1:0] rd_line;

  genvar i;
  generate
    for (i = 0; i < `DNH_TRIP_RECS; i = i + 1) begin : g_rec
      if (i == 0) begin : g_head
        always @(posedge clk) begin
          if (!rst_n) begin
            rec_r[i] <= {`DNH_TRIP_BITS{1'b0}};
          end else if (capture) begin
            rec_r[i] <= new_rec;
          end
        end
      end else begin : g_tail
        always @(posedge clk) begin
          if (!rst_n) begin
            rec_r[i] <= {`DNH_TRIP_BITS{1'b0}};
          end else if (capture) begin
            rec_r[i] <= rec_r[i-1];
          end
        end
      end
    end
  endgenerate

  assign rd_line = rec_r[rd_rec];
  assign rd_word = rd_line[rd_fld*16 +: 16];

endmodule // dnh_trip_store

// >>> dnh_regbank.v
`timescale 1ns/1ps
`include "dnh_map.vh"
// What this block does
// - values wider than a word sit in two registers, upper then lower.
// - frequency command pair, 0 to 40000, used only when source is 03.
// - read-only detailed run state word, codes 0 and 2 through 9.
// - read-only coarse state: 0 stopping, 1 running, 2 tripping.
// - read-only motion state word, codes 1 through 10.
// - written values are divided by their factor to give engineering units.
// - network values are plain binary integers, often times ten or hundred.
// - when network range exceeds internal range, one lsb is a fraction.
// - only read-write registers take writes; read-only ones return data.
// - each trip record keeps the trip factor and drive state codes.
// - each trip record keeps output current in 0.01 A steps, read-only.
// - each trip record keeps dc voltage in 0.1 V steps, read-only.
// - each trip record keeps running hours as an upper and lower word.
// - each trip record keeps power-on hours as an upper and lower word.
module dnh_regbank (
  input wire clk,
  input wire rst_n,
  // holding register access
  input wire reg_req,
  input wire reg_wr,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output reg reg_ack,
  output reg reg_exc,
  // drive side
  input wire [7:0] frequency_source_select,
  input wire [3:0] detailed_run_state_in,
  input wire [1:0] coarse_run_state_in,
  input wire [3:0] motion_state_in,
  output reg output_frequency_valid,
  output wire [15:0] output_frequency_hz,
  output wire [6:0] output_frequency_centi,
  output wire [15:0] loop_feedback_pct,
  output wire [6:0] loop_feedback_centi,
  // trip capture
  input wire trip_evt,
  input wire [15:0] trip_factor_in,
  input wire [15:0] trip_state_in,
  input wire [31:0] trip_freq_in,
  input wire [15:0] trip_current_in,
  input wire [15:0] trip_voltage_in,
  input wire [31:0] trip_run_hours_in,
  input wire [31:0] trip_pon_hours_in,
  output wire [15:0] trip_count_monitor
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  reg [31:0] freq_cmd_r;
  reg [31:0] freq_cmd_nxt;
  reg [15:0] freq_hi_stage_r;
  reg [15:0] freq_hi_stage_nxt;
  reg [15:0] loop_fb_r;
  reg [15:0] loop_fb_nxt;
  reg [15:0] trip_cnt_r;
  reg [15:0] trip_cnt_nxt;
  reg freq_load_r;
  reg freq_load_nxt;
  reg fb_load_r;
  reg fb_load_nxt;
  reg [15:0] rdata_nxt;
  reg exc_nxt;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  localparam [15:0] TRIP_SPAN = `DNH_TRIP_RECS * `DNH_TRIP_WORDS;
  localparam [15:0] TRIP_WORDS16 = `DNH_TRIP_WORDS;

  wire [15:0] trip_off;
  wire [15:0] trip_rec16;
  wire [15:0] trip_fld16;
  wire in_trip;
  wire in_rsvd;
  wire [15:0] trip_word;
  wire [31:0] freq_candidate;

  assign trip_off = reg_addr - `DNH_REG_TRIP_BASE;
  assign in_trip = (reg_addr >= `DNH_REG_TRIP_BASE) &&
                   (trip_off < TRIP_SPAN);
  assign trip_rec16 = trip_off / TRIP_WORDS16;
  assign trip_fld16 = trip_off % TRIP_WORDS16;
  assign in_rsvd = (reg_addr >= `DNH_REG_RSVD_FIRST) &&
                   (reg_addr <= `DNH_REG_RSVD_LAST);

  // upper word staged until the lower word completes the pair
  assign freq_candidate = {freq_hi_stage_r, reg_wdata};

  // ---------------------------------------------------------------
  // trip record capture
  // ---------------------------------------------------------------
  wire [`DNH_TRIP_BITS-1:0] trip_rec_new;

  // whole record packed from one cycle's inputs
  assign trip_rec_new = {
    trip_pon_hours_in[15:0],
    trip_pon_hours_in[31:16],
    trip_run_hours_in[15:0],
    trip_run_hours_in[31:16],
    trip_voltage_in,
    trip_current_in,
    trip_freq_in[15:0],
    trip_freq_in[31:16],
    trip_state_in,
    trip_factor_in
  };

  dnh_trip_store u_store (
    .clk(clk),
    .rst_n(rst_n),
    .capture(trip_evt),
    .new_rec(trip_rec_new),
    .rd_rec(trip_rec16[2:0]),
    .rd_fld(trip_fld16[3:0]),
    .rd_word(trip_word)
  );

  always @* begin
    trip_cnt_nxt = trip_cnt_r;
    // counter stops at its top value
    if (trip_evt && (trip_cnt_r < `DNH_TRIP_CNT_MAX)) begin
      trip_cnt_nxt = trip_cnt_r + 16'h0001;
    end
  end

  assign trip_count_monitor = trip_cnt_r;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always @* begin
    freq_cmd_nxt = freq_cmd_r;
    freq_hi_stage_nxt = freq_hi_stage_r;
    loop_fb_nxt = loop_fb_r;
    freq_load_nxt = 1'b0;
    fb_load_nxt = 1'b0;
    if (reg_req && reg_wr) begin
      if (reg_addr == `DNH_REG_FREQ_HI) begin
        freq_hi_stage_nxt = reg_wdata;
      end else if (reg_addr == `DNH_REG_FREQ_LO) begin
        // out-of-range pair is refused whole
        if (freq_candidate <= `DNH_FREQ_MAX) begin
          freq_cmd_nxt = freq_candidate;
          freq_load_nxt = 1'b1;
        end
      end else if (reg_addr == `DNH_REG_LOOP_FB) begin
        if (reg_wdata <= `DNH_LOOP_FB_MAX) begin
          loop_fb_nxt = reg_wdata;
          fb_load_nxt = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read data and exception
  // ---------------------------------------------------------------
  always @* begin
    rdata_nxt = 16'h0000;
    exc_nxt = 1'b0;
    if (reg_addr == `DNH_REG_UNUSED) begin
      exc_nxt = 1'b1;
    end else if (reg_addr == `DNH_REG_FREQ_HI) begin
      rdata_nxt = freq_cmd_r[31:16];
    end else if (reg_addr == `DNH_REG_FREQ_LO) begin
      rdata_nxt = freq_cmd_r[15:0];
      if (reg_wr && (freq_candidate > `DNH_FREQ_MAX)) begin
        exc_nxt = 1'b1;
      end
    end else if (reg_addr == `DNH_REG_DETAIL) begin
      rdata_nxt = {12'h000, detailed_run_state_in};
      exc_nxt = reg_wr;
    end else if (reg_addr == `DNH_REG_COARSE) begin
      rdata_nxt = {14'h0000, coarse_run_state_in};
      exc_nxt = reg_wr;
    end else if (reg_addr == `DNH_REG_MOTION) begin
      rdata_nxt = {12'h000, motion_state_in};
      exc_nxt = reg_wr;
    end else if (reg_addr == `DNH_REG_LOOP_FB) begin
      rdata_nxt = loop_fb_r;
      if (reg_wr && (reg_wdata > `DNH_LOOP_FB_MAX)) begin
        exc_nxt = 1'b1;
      end
    end else if (in_rsvd) begin
      exc_nxt = reg_wr;
    end else if (reg_addr == `DNH_REG_TRIP_CNT) begin
      rdata_nxt = trip_cnt_r;
      exc_nxt = reg_wr;
    end else if (in_trip) begin
      rdata_nxt = trip_word;
      exc_nxt = reg_wr;
    end else begin
      exc_nxt = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // state update
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      freq_cmd_r <= `DNH_FREQ_RST;
      freq_hi_stage_r <= 16'h0000;
      loop_fb_r <= `DNH_LOOP_FB_RST;
      trip_cnt_r <= 16'h0000;
      freq_load_r <= 1'b0;
      fb_load_r <= 1'b0;
      reg_rdata <= 16'h0000;
      reg_ack <= 1'b0;
      reg_exc <= 1'b0;
      output_frequency_valid <= 1'b0;
    end else begin
      freq_cmd_r <= freq_cmd_nxt;
      freq_hi_stage_r <= freq_hi_stage_nxt;
      loop_fb_r <= loop_fb_nxt;
      trip_cnt_r <= trip_cnt_nxt;
      freq_load_r <= freq_load_nxt;
      fb_load_r <= fb_load_nxt;
      reg_ack <= reg_req;
      reg_rdata <= reg_req ? rdata_nxt : 16'h0000;
      reg_exc <= reg_req & exc_nxt;
      // command takes effect only with network as source
      output_frequency_valid <=
        (frequency_source_select == `DNH_SRC_NETWORK);
    end
  end

  // ---------------------------------------------------------------
  // scaling to engineering units
  // ---------------------------------------------------------------
  // fraction below the internal step kept as hundredths
  dnh_scale u_freq_scale (
    .clk(clk),
    .rst_n(rst_n),
    .load(freq_load_r),
    .net_value(freq_cmd_r[15:0]),
    .whole(output_frequency_hz),
    .hundredths(output_frequency_centi)
  );

  dnh_scale u_fb_scale (
    .clk(clk),
    .rst_n(rst_n),
    .load(fb_load_r),
    .net_value(loop_fb_r),
    .whole(loop_feedback_pct),
    .hundredths(loop_feedback_centi)
  );

endmodule // dnh_regbank

// >>> dnh_regbank_assertions.sv
`timescale 1ns/1ps
module dnh_regbank_assertions (
  input wire clk,
  input wire rst_n,
  input wire reg_req,
  input wire reg_wr,
  input wire reg_ack,
  input wire reg_exc,
  input wire trip_evt,
  input wire output_frequency_valid,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_rdata,
  input wire [15:0] output_frequency_hz,
  input wire [15:0] trip_count_monitor,
  input wire [7:0] frequency_source_select,
  input wire [3:0] detailed_run_state_in,
  input wire [3:0] motion_state_in,
  input wire [1:0] coarse_run_state_in,
  input wire [6:0] output_frequency_centi
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_one_cycle: assert property (
    $past(rst_n) |-> reg_ack == $past(reg_req)) else $error("ack timing");
  a_exc_with_ack: assert property (
    reg_exc |-> reg_ack) else $error("exc without ack");
  a_ro_write_refused: assert property (
    reg_req && reg_wr && reg_addr inside {[16'h3:16'h5], [16'h7:16'h43]}
    |=> reg_exc) else $error("read-only write accepted");
  a_detail_read: assert property (
    reg_req && !reg_wr && reg_addr == 16'h3
    |=> reg_rdata == {12'h0, $past(detailed_run_state_in)})
    else $error("detailed state read wrong");
  a_coarse_read: assert property (
    reg_req && !reg_wr && reg_addr == 16'h4
    |=> reg_rdata == {14'h0, $past(coarse_run_state_in)})
    else $error("coarse state read wrong");
  a_motion_read: assert property (
    reg_req && !reg_wr && reg_addr == 16'h5
    |=> reg_rdata == {12'h0, $past(motion_state_in)})
    else $error("motion state read wrong");
  a_source_gate: assert property (
    $past(rst_n) |-> output_frequency_valid ==
    ($past(frequency_source_select) == 8'h03)) else $error("valid wrong");
  a_freq_ceiling: assert property (
    output_frequency_hz * 32'h64 + output_frequency_centi <= 32'h9c40 &&
    output_frequency_centi < 7'h64) else $error("frequency out of range");
  a_count_step: assert property (
    trip_evt && trip_count_monitor != 16'hfffa
    |=> trip_count_monitor == $past(trip_count_monitor) + 16'h1)
    else $error("trip count did not step");
  a_count_ceiling: assert property (
    trip_count_monitor <= 16'hfffa) else $error("trip count past limit");
endmodule // dnh_regbank_assertions

bind dnh_regbank dnh_regbank_assertions u_chk (
  .clk(clk),
  .rst_n(rst_n),
  .reg_req(reg_req),
  .reg_wr(reg_wr),
  .reg_ack(reg_ack),
  .reg_exc(reg_exc),
  .trip_evt(trip_evt),
  .output_frequency_valid(output_frequency_valid),
  .reg_addr(reg_addr),
  .reg_rdata(reg_rdata),
  .output_frequency_hz(output_frequency_hz),
  .trip_count_monitor(trip_count_monitor),
  .frequency_source_select(frequency_source_select),
  .detailed_run_state_in(detailed_run_state_in),
  .motion_state_in(motion_state_in),
  .coarse_run_state_in(coarse_run_state_in),
  .output_frequency_centi(output_frequency_centi)
);

// >>> dnh_host.sv
`timescale 1ns/1ps
module dnh_host (
  input wire clk,
  output logic reg_req,
  output logic reg_wr,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire reg_ack,
  input wire reg_exc
);
  int hung = 0;
  initial {reg_req, reg_wr, reg_addr, reg_wdata} = '0;
  // setting in whole units and hundredths to network integer
  function automatic [15:0] to_net(input int whole, centi);
    return 16'(whole * 100 + centi);
  endfunction
  function automatic [31:0] join_halves(input [15:0] hi, lo);
    return {hi, lo};
  endfunction
  task automatic access(input bit w, input [15:0] a, d,
                        output [15:0] rd, output e);
    int n;
    @(negedge clk);
    reg_req = 1'b1;
    reg_wr = w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    // released lines must not keep the old value
    reg_req = 1'b0;
    reg_wr = ~w;
    reg_addr = ~a;
    reg_wdata = ~d;
    n = 0;
    while (reg_ack !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n == 4) hung++;
    rd = reg_rdata;
    e = reg_exc;
  endtask
endmodule // dnh_host

// >>> dnh_regbank_bench.sv
`timescale 1ns/1ps
`include "dnh_map.vh"
`define CHK(nm, ex, ac) begin checked++; if ((ac) !== (ex)) begin \
  failures++; $display("[FAIL] %s exp %h got %h", nm, ex, ac); end end
module dnh_regbank_bench;
  logic clk = 0, rst_n = 0, trip_evt = 0, e, v;
  logic [7:0] frequency_source_select = 0;
  logic [3:0] detailed_run_state_in = 0, motion_state_in = 0;
  logic [1:0] coarse_run_state_in = 0;
  logic [159:0] recv = '0;
  logic [159:0] hist [$];
  logic [15:0] rd, fb, hi;
  logic [15:0] zr [5] = '{16'h1, 16'h2, 16'h6, 16'h11, 16'h12};
  wire reg_req, reg_wr, reg_ack, reg_exc, output_frequency_valid;
  wire [15:0] reg_addr, reg_wdata, reg_rdata, output_frequency_hz;
  wire [15:0] loop_feedback_pct, trip_count_monitor;
  wire [6:0] output_frequency_centi, loop_feedback_centi;
  int failures = 0, checked = 0, i, n;
  always #2.5 clk = ~clk;
  dnh_host u_host (.clk(clk), .reg_req(reg_req), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_exc(reg_exc));
  dnh_regbank u_dut (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_exc(reg_exc),
    .frequency_source_select(frequency_source_select),
    .detailed_run_state_in(detailed_run_state_in),
    .coarse_run_state_in(coarse_run_state_in),
    .motion_state_in(motion_state_in),
    .output_frequency_valid(output_frequency_valid),
    .output_frequency_hz(output_frequency_hz),
    .output_frequency_centi(output_frequency_centi),
    .loop_feedback_pct(loop_feedback_pct),
    .loop_feedback_centi(loop_feedback_centi),
    .trip_evt(trip_evt), .trip_count_monitor(trip_count_monitor),
    .trip_factor_in(recv[15:0]),
    .trip_state_in(recv[31:16]), .trip_freq_in({recv[47:32], recv[63:48]}),
    .trip_current_in(recv[79:64]), .trip_voltage_in(recv[95:80]),
    .trip_run_hours_in({recv[111:96], recv[127:112]}),
    .trip_pon_hours_in({recv[143:128], recv[159:144]}));
  task rd_chk(input [15:0] a, ev, input xe);
    u_host.access(1'b0, a, 16'h0, rd, e);
    if (u_host.hung != 0) end_sim;
    `CHK("rdata", ev, rd)
    `CHK("exc", xe, e)
  endtask
  task wr_chk(input [15:0] a, d, input xe);
    u_host.access(1'b1, a, d, rd, e);
    if (u_host.hung != 0) end_sim;
    `CHK("wexc", xe, e)
  endtask
  task end_sim;
    failures += u_host.hung;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h5ba2));
    repeat (16) @(negedge clk);
    rst_n = 1;
    foreach (zr[j]) rd_chk(zr[j], 16'h0, 1'b0);
    rd_chk(16'h0, 16'h0, 1'b1);
    rd_chk(16'h44, 16'h0, 1'b1);
    rd_chk(16'h7, 16'h0, 1'b0);
    $display("test reset done");
    repeat (8) begin
      detailed_run_state_in = 4'($urandom % 10);
      coarse_run_state_in = 2'($urandom % 3);
      motion_state_in = 4'($urandom % 11);
      rd_chk(16'h3, {12'h0, detailed_run_state_in}, 1'b0);
      rd_chk(16'h4, {14'h0, coarse_run_state_in}, 1'b0);
      rd_chk(16'h5, {12'h0, motion_state_in}, 1'b0);
      wr_chk(16'h3 + 16'($urandom % 3), 16'h1, 1'b1);
      wr_chk(16'h7 + 16'($urandom % 61), 16'h1, 1'b1);
    end
    $display("test status done");
    for (i = 0; i < 8; i++) begin
      n = (i == 0) ? 40000 : (i == 1) ? 0 : $urandom % 40001;
      fb = (i == 0) ? 16'h2710 : u_host.to_net($urandom % 100, $urandom % 100);
      frequency_source_select = (i % 2) ? 8'h03 : 8'($urandom);
      wr_chk(16'h1, 16'(n >> 16), 1'b0);
      wr_chk(16'h2, 16'(n), 1'b0);
      wr_chk(16'h2, 16'h9c41, 1'b1);
      wr_chk(16'h6, fb, 1'b0);
      wr_chk(16'h6, 16'h2711, 1'b1);
      rd_chk(16'h1, 16'(n >> 16), 1'b0);
      hi = rd;
      rd_chk(16'h2, 16'(n), 1'b0);
      `CHK("pair", 32'(n), u_host.join_halves(hi, rd))
      rd_chk(16'h6, fb, 1'b0);
      `CHK("hz", 16'(n / 100), output_frequency_hz)
      `CHK("centi", 7'(n % 100), output_frequency_centi)
      `CHK("pct", fb / 16'd100, loop_feedback_pct)
      `CHK("fbcenti", 7'(fb % 16'd100), loop_feedback_centi)
      v = (frequency_source_select == 8'h03);
      `CHK("valid", v, output_frequency_valid)
    end
    $display("test scaling done");
    for (i = 0; i < 7; i++) begin
      @(negedge clk);
      recv = {$urandom, $urandom, $urandom, $urandom, $urandom};
      trip_evt = 1'b1;
      hist.push_front(recv);
    end
    @(negedge clk);
    trip_evt = 1'b0;
    recv = '1;
    `CHK("count", 16'd7, trip_count_monitor)
    rd_chk(16'h11, 16'd7, 1'b0);
    for (i = 0; i < 5; i++)
      for (n = 0; n < 10; n++) begin
        hi = 16'(18 + 10 * i + n);
        fb = hist[i][16 * n +: 16];
        rd_chk(hi, fb, 1'b0);
      end
    $display("test trips done");
    end_sim;
  end
endmodule // dnh_regbank_bench
